// ### brfd_consts.vh
`ifndef BRFD_CONSTS_VH
`define BRFD_CONSTS_VH
// Address map
`define BRFD_WR_NIB      4'hc
`define BRFD_SYS_NIB     4'hd
`define BRFD_UPPER_HI    2'b11
`define BRFD_FLAGS_ADDR  8'hd5
`define BRFD_PTRA_ADDR   8'hd6
`define BRFD_PTRB_ADDR   8'hd7
`define BRFD_BANK_BIT    0
// Reset values
`define BRFD_FLAGS_RST   8'h00
`define BRFD_PTRA_RST    8'hc0
`define BRFD_PTRB_RST    8'hc8
// Bit operations
`define BRFD_BOP_NONE    2'h0
`define BRFD_BOP_SET     2'h1
`define BRFD_BOP_CLR     2'h2
`define BRFD_BOP_CPL     2'h3
// Physical index layout: 0-255 main and second set, 256-319 ctl banks, 320-351 first set
`define BRFD_CTL_BASE    9'h100
`define BRFD_SET1_BASE   9'h140
`define BRFD_SET1_HI     4'ha
`define BRFD_PHYS_W      9
`endif

// ### brfd_decode.v
`timescale 1ns/100ps
`include "brfd_consts.vh"
module brfd_decode (
	// Request
	input  wire [7:0] addr,
	input  wire       reg_mode,
	input  wire       bank,
	input  wire [7:0] ptr_a,
	input  wire [7:0] ptr_b,
	// Result
	output reg  [8:0] phys,
	output reg        impl
);
	reg [7:0] eff;

	// Function: implemented mode/control location within a bank
	function ctl_impl;
		input       b;
		input [4:0] o;
		begin
			if (!b)
				ctl_impl = (o <= 5'h05) || (o >= 5'h0b && o <= 5'h0d) || o == 5'h0f ||
				           o == 5'h10 || o == 5'h11 || (o >= 5'h14);
			else
				ctl_impl = (o <= 5'h05) || o == 5'h10 || o == 5'h11 ||
				           (o >= 5'h18 && o <= 5'h1b) || o == 5'h1e || o == 5'h1f;
		end
	endfunction

	// Working-register redirection and set/bank selection
	always @* begin
		eff  = addr;
		phys = {1'b0, addr};
		impl = 1'b1;
		if (reg_mode && addr[7:4] == `BRFD_WR_NIB)
			eff = addr[3] ? {ptr_b[7:3], addr[2:0]} : {ptr_a[7:3], addr[2:0]};
		if (!reg_mode) begin
			phys = {1'b0, addr};
		end else if (eff[7:6] != `BRFD_UPPER_HI) begin
			phys = {1'b0, eff};
		end else if (eff[7:5] == 3'b111) begin
			phys = `BRFD_CTL_BASE + {3'h0, bank, eff[4:0]};
			impl = ctl_impl(bank, eff[4:0]);
		end else begin
			phys = `BRFD_SET1_BASE + {4'h0, eff[4:0]};
		end
	end
endmodule

// ### brfd_regfile.v
`timescale 1ns/100ps
`include "brfd_consts.vh"
module brfd_regfile (
	// Clock and reset
	input  wire       clk,
	input  wire       arst_n,
	// Access port
	input  wire       acc_en,
	input  wire       acc_we,
	input  wire       acc_word,
	input  wire       acc_reg_mode,
	input  wire       acc_nib,
	input  wire [7:0] acc_addr,
	input  wire [15:0] acc_wdata,
	input  wire [1:0] acc_bop,
	input  wire [2:0] acc_bit,
	// Pointer load
	input  wire       load_group_base_op,
	input  wire [7:0] load_group_base_a,
	input  wire [7:0] load_group_base_b,
	input  wire [1:0] load_group_base_sel,
	// Results
	output reg  [15:0] rd_data_q,
	output reg        rd_valid_q,
	output reg        bit_test_q,
	output reg  [7:0] group_base_ptr_a_q,
	output reg  [7:0] group_base_ptr_b_q,
	output reg        bank_q
);
	// Storage: 256 main, 64 banked, 32 first-set slots; 326 implemented
	reg  [7:0] mem [0:351];
	reg  [7:0] flags_q;
	wire [7:0] a0;
	wire [7:0] a1;
	wire [8:0] p0;
	wire [8:0] p1;
	wire       i0;
	wire       i1;
	wire       hit_fl0;
	wire       hit_pa0;
	wire       hit_pb0;
	wire       hit_fl1;
	wire       hit_pa1;
	wire       hit_pb1;
	wire [7:0] rv0;
	wire [7:0] rv1;
	integer    k;

	////////////////////////////////////////////////////////////////
	// Address formation: 4-bit field or full 8-bit code
	assign a0 = acc_nib ? {4'hc, acc_addr[3:1], acc_addr[0] & ~acc_word}
	                    : {acc_addr[7:1], acc_addr[0] & ~acc_word};
	assign a1 = a0 | 8'h01;

	// Even byte decode
	brfd_decode u_dec0 (
		.addr     (a0),
		.reg_mode (acc_reg_mode | acc_nib),
		.bank     (flags_q[`BRFD_BANK_BIT]),
		.ptr_a    (group_base_ptr_a_q),
		.ptr_b    (group_base_ptr_b_q),
		.phys     (p0),
		.impl     (i0)
	);

	// Odd byte decode for word access
	brfd_decode u_dec1 (
		.addr     (a1),
		.reg_mode (acc_reg_mode | acc_nib),
		.bank     (flags_q[`BRFD_BANK_BIT]),
		.ptr_a    (group_base_ptr_a_q),
		.ptr_b    (group_base_ptr_b_q),
		.phys     (p1),
		.impl     (i1)
	);

	////////////////////////////////////////////////////////////////
	// Function: first-set system location hit for one lane
	function sys_hit;
		input [8:0] p;
		input [7:0] code;
		begin
			sys_hit = (p[8:5] == `BRFD_SET1_HI) && ({3'b110, p[4:0]} == code);
		end
	endfunction

	// Function: byte read with flop registers, reserved at zero
	function [7:0] rd_byte;
		input       im;
		input       fl;
		input       pa;
		input       pb;
		input [7:0] fv;
		input [7:0] av;
		input [7:0] bv;
		input [7:0] mv;
		begin
			if (!im)
				rd_byte = 8'h00;
			else if (fl)
				rd_byte = fv;
			else if (pa)
				rd_byte = av;
			else if (pb)
				rd_byte = bv;
			else
				rd_byte = mv;
		end
	endfunction

	// System register hits; the odd lane counts only for word access
	assign hit_fl0 = sys_hit(p0, `BRFD_FLAGS_ADDR);
	assign hit_pa0 = sys_hit(p0, `BRFD_PTRA_ADDR);
	assign hit_pb0 = sys_hit(p0, `BRFD_PTRB_ADDR);
	assign hit_fl1 = acc_word && sys_hit(p1, `BRFD_FLAGS_ADDR);
	assign hit_pa1 = acc_word && sys_hit(p1, `BRFD_PTRA_ADDR);
	assign hit_pb1 = acc_word && sys_hit(p1, `BRFD_PTRB_ADDR);

	// Read values per lane
	assign rv0 = rd_byte(i0, hit_fl0, hit_pa0, hit_pb0, flags_q, group_base_ptr_a_q,
	                     group_base_ptr_b_q, mem[p0]);
	assign rv1 = rd_byte(i1, hit_fl1, hit_pa1, hit_pb1, flags_q, group_base_ptr_a_q,
	                     group_base_ptr_b_q, mem[p1]);

	// Bit operation on the addressed byte
	reg [7:0] bmod;
	always @* begin
		bmod = rv0;
		case (acc_bop)
			`BRFD_BOP_SET: bmod[acc_bit] = 1'b1;
			`BRFD_BOP_CLR: bmod[acc_bit] = 1'b0;
			`BRFD_BOP_CPL: bmod[acc_bit] = ~rv0[acc_bit];
			default:       bmod = acc_wdata[7:0];
		endcase
	end
	wire [7:0] wv0 = acc_word ? acc_wdata[15:8] : bmod;
	wire [7:0] wv1 = acc_wdata[7:0];
	wire       wr  = acc_en && (acc_we || acc_bop != `BRFD_BOP_NONE);
	wire       wr0 = wr && i0 && !hit_fl0 && !hit_pa0 && !hit_pb0;
	wire       wr1 = wr && acc_word && i1 && !hit_fl1 && !hit_pa1 && !hit_pb1;

	////////////////////////////////////////////////////////////////
	// Array writes
	always @(posedge clk) begin
		if (wr0)
			mem[p0] <= wv0;
		if (wr1)
			mem[p1] <= wv1;
	end

	// Flags register and its bank-select copy
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			flags_q <= `BRFD_FLAGS_RST;
			bank_q  <= 1'b0;
		end else if (wr && hit_fl0) begin
			flags_q <= wv0;
			bank_q  <= wv0[`BRFD_BANK_BIT];
		end else if (wr && hit_fl1) begin
			flags_q <= wv1;
			bank_q  <= wv1[`BRFD_BANK_BIT];
		end
	end

	// Pointer a: load operation wins over a register write
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			group_base_ptr_a_q <= `BRFD_PTRA_RST;
		else if (load_group_base_op && load_group_base_sel[0])
			group_base_ptr_a_q <= load_group_base_a;
		else if (wr && hit_pa0)
			group_base_ptr_a_q <= wv0;
		else if (wr && hit_pa1)
			group_base_ptr_a_q <= wv1;
	end

	// Pointer b: same priority as pointer a
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			group_base_ptr_b_q <= `BRFD_PTRB_RST;
		else if (load_group_base_op && load_group_base_sel[1])
			group_base_ptr_b_q <= load_group_base_b;
		else if (wr && hit_pb0)
			group_base_ptr_b_q <= wv0;
		else if (wr && hit_pb1)
			group_base_ptr_b_q <= wv1;
	end

	// Registered read result, one cycle after request
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rd_data_q  <= 16'h0000;
			rd_valid_q <= 1'b0;
			bit_test_q <= 1'b0;
		end else begin
			rd_valid_q <= acc_en && !acc_we;
			if (acc_en && !acc_we) begin
				rd_data_q  <= acc_word ? {rv0, rv1} : {8'h00, rv0};
				bit_test_q <= rv0[acc_bit];
			end
		end
	end

	// Simulation start value; the array itself has no reset
	initial begin
		for (k = 0; k < 352; k = k + 1)
			mem[k] = 8'h00;
	end
endmodule

// ### brfd_monitor.sv
`timescale 1ns/100ps
module brfd_mon (
	// Clock and reset
	input logic        clk,
	input logic        arst_n,
	// Access port
	input logic        acc_en,
	input logic        acc_we,
	input logic        acc_word,
	input logic        acc_reg_mode,
	input logic        acc_nib,
	input logic [7:0]  acc_addr,
	input logic [15:0] acc_wdata,
	input logic [1:0]  acc_bop,
	input logic [2:0]  acc_bit,
	// Pointer load
	input logic        load_group_base_op,
	input logic [7:0]  load_group_base_a,
	input logic [7:0]  load_group_base_b,
	input logic [1:0]  load_group_base_sel,
	// Results
	input logic [15:0] rd_data_q,
	input logic        rd_valid_q,
	input logic        bit_test_q,
	input logic [7:0]  group_base_ptr_a_q,
	input logic [7:0]  group_base_ptr_b_q,
	input logic        bank_q
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);
	// Plain read and register-mode byte read
	wire rd_req = acc_en && !acc_we && acc_bop == 2'h0;
	wire rm_byte = rd_req && acc_reg_mode && !acc_nib && !acc_word;
	// Word write, idle cycle, word read back
	sequence s_wr_word;
		acc_en && acc_we && acc_word && acc_bop == 2'h0 && !acc_nib && acc_addr < 8'hc0;
	endsequence
	sequence s_rd_same;
		rd_req && acc_word && !acc_nib && acc_addr == $past(acc_addr, 2);
	endsequence
	a_read_valid: assert property (rd_req |=> rd_valid_q) else $error("read unanswered");
	a_idle_quiet: assert property (!acc_en |=> !rd_valid_q) else $error("stray valid");
	a_ptr_reset: assert property ($rose(arst_n) |-> group_base_ptr_a_q == 8'hc0 && group_base_ptr_b_q == 8'hc8)
		else $error("pointer reset");
	a_ptr_load: assert property (load_group_base_op && load_group_base_sel[0]
		|=> group_base_ptr_a_q == $past(load_group_base_a)) else $error("pointer load");
	a_ptrb_load: assert property (load_group_base_op && load_group_base_sel[1]
		|=> group_base_ptr_b_q == $past(load_group_base_b)) else $error("pointer b load");
	a_flag_bank: assert property (rm_byte && acc_addr == 8'hd5
		|=> rd_data_q[15:8] == 8'h00 && rd_data_q[0] == bank_q) else $error("bank bit");
	a_word_echo: assert property (s_wr_word ##2 s_rd_same |=> rd_data_q == $past(acc_wdata, 3))
		else $error("word pair");
	a_bit_test: assert property (rd_req && !acc_word |=> bit_test_q == rd_data_q[$past(acc_bit)])
		else $error("bit test");
	a_reserved_zero: assert property (rm_byte && acc_addr == 8'hee |=> rd_data_q == 16'h0000)
		else $error("reserved read");
endmodule
bind brfd_regfile brfd_mon mon_u (.*);

// ### brfd_cpu_model.sv
`timescale 1ns/100ps
module brfd_cpu_model (
	// Clock and read data
	input logic         clk,
	input logic [15:0]  rd_data_q,
	// Access request
	output logic        acc_en = 1'b0,
	output logic        acc_we = 1'b0,
	output logic        acc_word = 1'b0,
	output logic        acc_reg_mode = 1'b0,
	output logic        acc_nib = 1'b0,
	output logic [7:0]  acc_addr = 8'h00,
	output logic [15:0] acc_wdata = 16'h0000,
	output logic [1:0]  acc_bop = 2'h0,
	output logic [2:0]  acc_bit = 3'h0,
	// Pointer load
	output logic        load_group_base_op = 1'b0,
	output logic [7:0]  load_group_base_a = 8'h00,
	output logic [7:0]  load_group_base_b = 8'h00,
	output logic [1:0]  load_group_base_sel = 2'h0
);
	// One access, held across one sampling edge; f is we, word, reg, nibble
	task acc(input [3:0] f, input [7:0] ad, input [15:0] wd, input [1:0] op, input [2:0] b, output [15:0] q);
		@(negedge clk);
		{acc_we, acc_word, acc_reg_mode, acc_nib} = f;
		{acc_addr, acc_wdata, acc_bop, acc_bit} = {ad, wd, op, b};
		acc_en = 1'b1;
		@(negedge clk);
		acc_en = 1'b0;
		q = rd_data_q;
	endtask
	// Pointer load pulse
	task ld(input [1:0] s, input [7:0] a, input [7:0] b);
		@(negedge clk);
		{load_group_base_sel, load_group_base_a, load_group_base_b} = {s, a, b};
		load_group_base_op = 1'b1;
		@(negedge clk);
		load_group_base_op = 1'b0;
	endtask
endmodule

// ### brfd_tb.sv
`timescale 1ns/100ps
module tb;
	logic        clk = 1'b0, arst_n = 1'b0, acc_en, acc_we, acc_word, acc_reg_mode, acc_nib;
	logic        load_group_base_op, rd_valid_q, bit_test_q, bank_q;
	logic [7:0]  acc_addr, load_group_base_a, load_group_base_b, group_base_ptr_a_q, group_base_ptr_b_q;
	logic [15:0] acc_wdata, rd_data_q, q;
	logic [1:0]  acc_bop, load_group_base_sel;
	logic [2:0]  acc_bit;
	int          error_cnt = 0, n_checks = 0, cyc = 0;
	localparam [3:0] RD = 4'b0000, RR = 4'b0010, RW = 4'b0100, WR = 4'b1000, WRR = 4'b1010, WW = 4'b1100, NW = 4'b1011;
	localparam [3:0] WWR = 4'b1110, RWR = 4'b0110;
	always #12.5 clk = ~clk;
	brfd_cpu_model cpu_u (.*);
	brfd_regfile dut_u (.*);
	task chk(input [15:0] s, input [15:0] e, input string n);
		n_checks++;
		if (s !== e) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	task end_of_test;
		if (error_cnt == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// Hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == 4000) begin
			error_cnt++;
			end_of_test;
		end
	end
	task t_reset;
		chk(group_base_ptr_a_q, 8'hc0, "ptr_a");
		chk(group_base_ptr_b_q, 8'hc8, "ptr_b");
	endtask
	task t_sets;
		cpu_u.acc(WRR, 8'hc5, 16'h11, 0, 0, q);
		cpu_u.acc(WR, 8'hc5, 16'h22, 0, 0, q);
		cpu_u.acc(WRR, 8'h10, 16'h77, 0, 0, q);
		cpu_u.acc(RR, 8'hc5, 0, 0, 0, q);
		chk(q, 16'h0011, "first set");
		cpu_u.acc(RD, 8'hc5, 0, 0, 0, q);
		chk(q, 16'h0022, "second set");
		cpu_u.acc(RD, 8'h10, 0, 0, 0, q);
		chk(q, 16'h0077, "low code");
	endtask
	task t_ptr;
		cpu_u.ld(2'b11, 8'h20, 8'h48);
		chk(group_base_ptr_a_q, 8'h20, "load a");
		chk(group_base_ptr_b_q, 8'h48, "load b");
		cpu_u.acc(NW, 8'h03, 16'h5a, 0, 0, q);
		cpu_u.acc(RD, 8'h23, 0, 0, 0, q);
		chk(q, 16'h005a, "nibble");
		cpu_u.acc(WR, 8'h4b, 16'h6c, 0, 0, q);
		cpu_u.acc(RR, 8'hcb, 0, 0, 0, q);
		chk(q, 16'h006c, "c-nibble");
		cpu_u.acc(WWR, 8'hd6, 16'hc0c8, 0, 0, q);
		chk(group_base_ptr_a_q, 8'hc0, "pair a");
		chk(group_base_ptr_b_q, 8'hc8, "pair b");
		cpu_u.acc(RWR, 8'hd7, 0, 0, 0, q);
		chk(q, 16'hc0c8, "pair read");
	endtask
	task t_word;
		cpu_u.acc(WW, 8'h31, 16'hbeef, 0, 0, q);
		chk(rd_valid_q, 1'b0, "no valid");
		cpu_u.acc(RW, 8'h31, 0, 0, 0, q);
		chk(q, 16'hbeef, "word");
		chk(rd_valid_q, 1'b1, "valid");
		cpu_u.acc(RD, 8'h30, 0, 0, 0, q);
		chk(q, 16'h00be, "even");
	endtask
	task t_bank;
		cpu_u.acc(WRR, 8'he0, 16'h33, 0, 0, q);
		cpu_u.acc(WRR, 8'hd5, 16'h01, 0, 0, q);
		chk(bank_q, 1'b1, "bank");
		cpu_u.acc(WRR, 8'he0, 16'h44, 0, 0, q);
		cpu_u.acc(RR, 8'he0, 0, 0, 0, q);
		chk(q, 16'h0044, "bank1");
		cpu_u.acc(RR, 8'hd5, 0, 0, 0, q);
		chk(q, 16'h0001, "flags");
		cpu_u.acc(WRR, 8'hd5, 16'h00, 0, 0, q);
		cpu_u.acc(RR, 8'he0, 0, 0, 0, q);
		chk(q, 16'h0033, "bank0");
		cpu_u.acc(WRR, 8'hee, 16'h55, 0, 0, q);
		cpu_u.acc(RR, 8'hee, 0, 0, 0, q);
		chk(q, 16'h0000, "reserved");
	endtask
	task t_bits;
		cpu_u.acc(WR, 8'h40, 16'h00, 0, 0, q);
		cpu_u.acc(WR, 8'h40, 0, 2'h1, 3'h7, q);
		cpu_u.acc(WR, 8'h40, 0, 2'h3, 3'h0, q);
		cpu_u.acc(RD, 8'h40, 0, 0, 3'h7, q);
		chk(q, 16'h0081, "set cpl");
		chk(bit_test_q, 1'b1, "test");
		cpu_u.acc(WR, 8'h40, 0, 2'h2, 3'h7, q);
		cpu_u.acc(RD, 8'h40, 0, 0, 0, q);
		chk(q, 16'h0001, "clear");
	endtask
	// Main sequence
	initial begin
		repeat (12) @(negedge clk);
		arst_n = 1'b1;
		t_reset;
		t_sets;
		t_ptr;
		t_word;
		t_bank;
		t_bits;
		end_of_test;
	end
endmodule
